// ==== src/nfcci_consts.svh ====
// register indices, field positions and reset values of the reader control block
`ifndef NFCCI_CONSTS_SVH
`define NFCCI_CONSTS_SVH
// register indices; byte address is four times the index
`define NFCCI_IDX_CMD 10'h001
`define NFCCI_IDX_IEN1 10'h002
`define NFCCI_IDX_IEN2 10'h003
`define NFCCI_IDX_REQ 10'h004
`define NFCCI_IDX_STAT1 10'h007
// field positions
`define NFCCI_CMD_RXOFF_BIT 5
`define NFCCI_CMD_SLEEP_BIT 4
`define NFCCI_IEN1_POL_BIT 7
`define NFCCI_IEN2_DRV_BIT 7
`define NFCCI_REQ_IDLE_BIT 4
`define NFCCI_REQ_N 7
// reset values
`define NFCCI_CMD_RST 8'h20
`define NFCCI_IEN1_RST 8'h80
`define NFCCI_IEN2_RST 8'h00
`define NFCCI_REQ_RST 7'h14
`define NFCCI_CODE_IDLE 4'h0
`endif

// ==== src/nfcci_pkg.sv ====
// types shared by the reader control block
package nfcci_pkg;
    // command sequencer states, gray along idle, launch, busy
    typedef enum logic [1:0] {
        NFCCI_ST_IDLE = 2'b00,
        NFCCI_ST_LAUNCH = 2'b01,
        NFCCI_ST_BUSY = 2'b11
    } nfcci_state_t;
endpackage

// ==== src/nfcci_flag_bank.sv ====
// sticky request flags, hardware set wins over software clear
`timescale 1ns/1ps
`default_nettype none
module nfcci_flag_bank import nfcci_pkg::*; #(
    parameter int W = 7,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // set and clear strobes
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    // flag state
    output logic [W-1:0] flags_q
);
    logic [W-1:0] flags_d;

    assign flags_d = (flags_q & ~clr_i) | set_i;

    // flag storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // a set in the clearing cycle must survive
    a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (set_i != '0) |=> ((flags_q & $past(set_i)) == $past(set_i)))
        else $error("flag set lost");
endmodule
`default_nettype wire

// ==== src/nfcci_irq_pin.sv ====
// interrupt pin driver with polarity and drive type selection
`timescale 1ns/1ps
`default_nettype none
module nfcci_irq_pin import nfcci_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic status_i,
    input wire logic irq_polarity_select,
    input wire logic irq_drive_type,
    // pin, enable active low
    output logic pin_o,
    output logic pin_oe_n
);
    logic level;

    // pin equals status, or its inverse
    assign level = status_i ^ irq_polarity_select;

    // open drain only pulls low; push-pull drives both levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_o <= 1'b0;
            pin_oe_n <= 1'b1;
        end else if (irq_drive_type) begin
            pin_o <= level;
            pin_oe_n <= 1'b0;
        end else begin
            pin_o <= 1'b0;
            pin_oe_n <= level;
        end
    end

    a_pin_pushpull: assert property (@(posedge pclk) disable iff (!presetn)
        irq_drive_type |=> (!pin_oe_n && pin_o == $past(status_i ^ irq_polarity_select)))
        else $error("push-pull pin level wrong");

    a_pin_opendrain: assert property (@(posedge pclk) disable iff (!presetn)
        (!irq_drive_type && irq_polarity_select && !status_i) |=> (pin_oe_n && !pin_o))
        else $error("idle open-drain pin not released");
endmodule
`default_nettype wire

// ==== src/nfcci_ctrl.sv ====
// reader command control and primary interrupt enable, apb slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "nfcci_consts.svh"
module nfcci_ctrl import nfcci_pkg::*; #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request events, bit 6 tx done down to bit 0 timer
    input wire logic [6:0] req_event_i,
    // command sequencer
    input wire logic cmd_done_i,
    output logic cmd_start_o,
    output logic [3:0] cmd_code_o,
    // analog and power control
    output logic receiver_analog_off,
    output logic soft_sleep_request,
    // interrupt outputs
    output logic irq_o,
    output logic reader_irq_pin_o,
    output logic reader_irq_pin_oe_n
);
    logic setup;
    logic wr_en;
    logic mapped;
    logic [AW-3:0] widx;
    logic [7:0] wbyte;
    logic sel_cmd;
    logic sel_ien1;
    logic sel_ien2;
    logic sel_req;
    logic sel_stat;
    logic [7:0] ien1_q;
    logic [7:0] ien2_q;
    logic [6:0] flags_q;
    logic [6:0] flag_set;
    logic [6:0] flag_clr;
    logic irq_status;
    logic cmd_wr;
    logic [3:0] wr_code;
    logic stop_req;
    logic launch_req;
    logic [31:0] rdata_d;
    nfcci_state_t state_q;
    nfcci_state_t state_d;

    // decode: word index from the byte address, low bits must be zero
    assign widx = paddr[AW-1:2];
    assign setup = psel && !penable;
    assign wbyte = pwdata[7:0];
    assign sel_cmd = (paddr[1:0] == 2'h0) && (widx == (AW-2)'(`NFCCI_IDX_CMD));
    assign sel_ien1 = (paddr[1:0] == 2'h0) && (widx == (AW-2)'(`NFCCI_IDX_IEN1));
    assign sel_ien2 = (paddr[1:0] == 2'h0) && (widx == (AW-2)'(`NFCCI_IDX_IEN2));
    assign sel_req = (paddr[1:0] == 2'h0) && (widx == (AW-2)'(`NFCCI_IDX_REQ));
    assign sel_stat = (paddr[1:0] == 2'h0) && (widx == (AW-2)'(`NFCCI_IDX_STAT1));
    assign mapped = sel_cmd || sel_ien1 || sel_ien2 || sel_req || sel_stat;

    // writes land only at the completing access edge
    assign wr_en = psel && penable && pready && pwrite;
    assign cmd_wr = wr_en && sel_cmd;
    assign wr_code = wbyte[3:0];

    // one wait-free access: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // error answer for addresses that hold no register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !mapped;
        end
    end

    // read mux, sampled in the setup cycle so prdata leaves a flop
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (sel_cmd) begin
            rdata_d[7:6] = 2'h0;
            rdata_d[`NFCCI_CMD_RXOFF_BIT] = receiver_analog_off;
            rdata_d[`NFCCI_CMD_SLEEP_BIT] = soft_sleep_request;
            // running code, not the last written one
            rdata_d[3:0] = cmd_code_o;
        end else if (sel_ien1) begin
            rdata_d[7:0] = ien1_q;
        end else if (sel_ien2) begin
            rdata_d[`NFCCI_IEN2_DRV_BIT] = ien2_q[`NFCCI_IEN2_DRV_BIT];
        end else if (sel_req) begin
            rdata_d[6:0] = flags_q;
        end else if (sel_stat) begin
            rdata_d[0] = irq_status;
        end
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receiver_analog_off <= 1'(`NFCCI_CMD_RST >> `NFCCI_CMD_RXOFF_BIT);
        end else if (cmd_wr) begin
            receiver_analog_off <= wbyte[`NFCCI_CMD_RXOFF_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_sleep_request <= 1'b0;
        end else if (cmd_wr) begin
            soft_sleep_request <= wbyte[`NFCCI_CMD_SLEEP_BIT];
        end
    end

    // a written code starts a command, the idle code stops one
    assign launch_req = cmd_wr && (wr_code != `NFCCI_CODE_IDLE);
    assign stop_req = cmd_wr && (wr_code == `NFCCI_CODE_IDLE);

    // command sequencer next state; a new code restarts a running command
    always_comb begin
        state_d = state_q;
        case (state_q)
            NFCCI_ST_IDLE: begin
                if (launch_req) begin
                    state_d = NFCCI_ST_LAUNCH;
                end
            end
            NFCCI_ST_LAUNCH: begin
                if (launch_req) begin
                    state_d = NFCCI_ST_LAUNCH;
                end else if (stop_req || cmd_done_i) begin
                    state_d = NFCCI_ST_IDLE;
                end else begin
                    state_d = NFCCI_ST_BUSY;
                end
            end
            NFCCI_ST_BUSY: begin
                if (launch_req) begin
                    state_d = NFCCI_ST_LAUNCH;
                end else if (stop_req || cmd_done_i) begin
                    state_d = NFCCI_ST_IDLE;
                end
            end
            default: begin
                state_d = NFCCI_ST_IDLE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= NFCCI_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // start strobe, one cycle per launch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_start_o <= 1'b0;
        end else begin
            cmd_start_o <= launch_req;
        end
    end

    // running code returns to idle when the command ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_code_o <= `NFCCI_CODE_IDLE;
        end else if (cmd_wr) begin
            cmd_code_o <= wr_code;
        end else if (cmd_done_i && state_q != NFCCI_ST_IDLE) begin
            cmd_code_o <= `NFCCI_CODE_IDLE;
        end
    end

    // enable bits and polarity live in the primary enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien1_q <= `NFCCI_IEN1_RST;
        end else if (wr_en && sel_ien1) begin
            ien1_q <= wbyte;
        end
    end

    // drive type; other bits of this register are not kept here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien2_q <= `NFCCI_IEN2_RST;
        end else if (wr_en && sel_ien2) begin
            ien2_q <= wbyte & 8'h80;
        end
    end

    // events and command end set flags, writing one clears
    always_comb begin
        flag_set = req_event_i;
        flag_clr = 7'h00;
        // leaving a running command raises the idle flag
        if ((cmd_done_i || stop_req) && state_q != NFCCI_ST_IDLE) begin
            flag_set[`NFCCI_REQ_IDLE_BIT] = 1'b1;
        end
        if (wr_en && sel_req) begin
            flag_clr = wbyte[6:0];
        end
    end

    nfcci_flag_bank #(
        .W(`NFCCI_REQ_N),
        .RST(`NFCCI_REQ_RST)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .flags_q(flags_q)
    );

    assign irq_status = |(flags_q & ien1_q[6:0]);

    // level interrupt, one flop behind the status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_status;
        end
    end

    // pin follows status through polarity and drive type
    nfcci_irq_pin u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .status_i(irq_status),
        .irq_polarity_select(ien1_q[`NFCCI_IEN1_POL_BIT]),
        .irq_drive_type(ien2_q[`NFCCI_IEN2_DRV_BIT]),
        .pin_o(reader_irq_pin_o),
        .pin_oe_n(reader_irq_pin_oe_n)
    );

    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> (pready && (pslverr == !$past(mapped))))
        else $error("apb answer wrong");

    a_receiver_analog_off_write: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr |=> (receiver_analog_off == $past(wbyte[5])))
        else $error("receiver control not written");

    a_sleep_write: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr |=> (soft_sleep_request == $past(wbyte[4])))
        else $error("power-down bit not written");

    a_launch_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        launch_req |=> (cmd_start_o && state_q == NFCCI_ST_LAUNCH) ##1 !cmd_start_o[*1])
        else $error("launch strobe wrong");

    a_code_running: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_done_i && !cmd_wr && state_q == NFCCI_ST_BUSY) |=>
        (cmd_code_o == 4'h0 && state_q == NFCCI_ST_IDLE && flags_q[4]))
        else $error("ended command still reported");

    a_cmd_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel_cmd) |=> (prdata[7:6] == 2'h0 && prdata[3:0] == $past(cmd_code_o)))
        else $error("command readback wrong");

    a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
        ((flags_q & ien1_q[6:0]) == 7'h00) |=> !irq_o)
        else $error("masked flag reached interrupt");

    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        irq_status |=> irq_o)
        else $error("interrupt missed enabled flag");

    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel_req && wbyte[0] && !req_event_i[0]) |=> !flags_q[0])
        else $error("flag not cleared");

    // a refused write must leave the registers alone; command end excluded
    a_unmapped_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && !mapped && !cmd_done_i) |=> ($stable(ien1_q) && $stable(ien2_q)
        && $stable(cmd_code_o) && $stable(receiver_analog_off)))
        else $error("refused write changed a register");

    a_idle_no_start: assert property (@(posedge pclk) disable iff (!presetn)
        stop_req |=> !cmd_start_o)
        else $error("idle code raised start strobe");

    a_stop_running: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_req && state_q != NFCCI_ST_IDLE) |=>
        (cmd_code_o == 4'h0 && state_q == NFCCI_ST_IDLE && flags_q[`NFCCI_REQ_IDLE_BIT]))
        else $error("stopped command still reported");

    a_drive_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel_ien2) |=> (ien2_q == {$past(wbyte[7]), 7'h00}))
        else $error("secondary enable content wrong");

    a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel_stat) |=> (prdata == {31'h0, $past(irq_status)}))
        else $error("status readback wrong");
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the reader command and interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`include "nfcci_consts.svh"
module tb_top;
    import nfcci_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] req_event_i = 7'h00;
    logic cmd_done_i = 1'b0;
    logic cmd_start_o;
    logic [3:0] cmd_code_o;
    logic receiver_analog_off;
    logic soft_sleep_request;
    logic irq_o;
    logic reader_irq_pin_o;
    logic reader_irq_pin_oe_n;
    int num_errors = 0;
    int n_compared = 0;
    int seed = 32'hf0881ef9;
    logic [31:0] rd;
    logic err;
    logic [7:0] wv;
    logic [1:0] pe;
    logic [6:0] en;
    logic [6:0] ev;
    logic pol;
    logic drv;
    logic st;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    nfcci_ctrl #(.AW(12)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_event_i(req_event_i), .cmd_done_i(cmd_done_i), .cmd_start_o(cmd_start_o),
        .cmd_code_o(cmd_code_o), .receiver_analog_off(receiver_analog_off),
        .soft_sleep_request(soft_sleep_request), .irq_o(irq_o),
        .reader_irq_pin_o(reader_irq_pin_o), .reader_irq_pin_oe_n(reader_irq_pin_oe_n)
    );

    // verdict and end of run, also reached by an exhausted wait
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // case-inequality compare so unknowns never match
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("ERROR pready expected 1 seen timeout");
            finish_test();
        end else begin
            // answer taken at the edge that samples pready, then released
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // expected {oe_n, data} of the interrupt pin
    function automatic logic [1:0] pin_exp(input logic s, input logic p, input logic d);
        logic lv;
        lv = s ^ p;
        if (d) begin
            return {1'b0, lv};
        end
        return lv ? 2'b10 : 2'b00;
    endfunction

    // pin compared only while driven; released data is meaningless
    task automatic chk_pin(input logic s, input logic p, input logic d);
        pe = pin_exp(s, p, d);
        chk("pin_oe_n", {31'h0, pe[1]}, {31'h0, reader_irq_pin_oe_n});
        if (!pe[1]) begin
            chk("pin_o", {31'h0, pe[0]}, {31'h0, reader_irq_pin_o});
        end
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk_pin(1'b0, 1'b1, 1'b0);
        chk("rcv_off_rst", 32'h1, {31'h0, receiver_analog_off});
        // reset values from the register map
        apb(1'b0, `NFCCI_IDX_CMD, 8'h00);
        chk("cmd_rst", 32'h20, rd);
        chk("cmd_err", 32'h0, {31'h0, err});
        apb(1'b0, `NFCCI_IDX_IEN1, 8'h00);
        chk("ien1_rst", 32'h80, rd);
        apb(1'b0, `NFCCI_IDX_IEN2, 8'h00);
        chk("ien2_rst", 32'h00, rd);
        apb(1'b0, `NFCCI_IDX_REQ, 8'h00);
        chk("req_rst", 32'h14, rd);
        // unmapped place is refused and reads zero
        apb(1'b0, 10'h005, 8'h00);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_rd", 32'h0, rd);
        apb(1'b1, 10'h005, 8'hFF);
        chk("unmapped_wr_err", 32'h1, {31'h0, err});
        // launch, readback of running code, completion
        for (int i = 0; i < 8; i++) begin
            wv = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            apb(1'b1, `NFCCI_IDX_CMD, wv);
            #1;
            chk("cmd_start", {31'h0, wv[3:0] != 4'h0}, {31'h0, cmd_start_o});
            chk("cmd_code", {28'h0, wv[3:0]}, {28'h0, cmd_code_o});
            chk("rcv_off", {31'h0, wv[5]}, {31'h0, receiver_analog_off});
            chk("sleep", {31'h0, wv[4]}, {31'h0, soft_sleep_request});
            apb(1'b0, `NFCCI_IDX_CMD, 8'h00);
            chk("cmd_rd", {24'h0, 2'b00, wv[5:0]}, rd);
            apb(1'b1, `NFCCI_IDX_REQ, 8'h7F);
            @(posedge pclk);
            cmd_done_i <= 1'b1;
            @(posedge pclk);
            cmd_done_i <= 1'b0;
            #1;
            chk("code_done", 32'h0, {28'h0, cmd_code_o});
            apb(1'b0, `NFCCI_IDX_CMD, 8'h00);
            chk("cmd_rd_idle", {24'h0, 2'b00, wv[5:4], 4'h0}, rd);
            apb(1'b0, `NFCCI_IDX_REQ, 8'h00);
            chk("idle_flag", {31'h0, wv[3:0] != 4'h0}, {31'h0, rd[4]});
        end
        // a new code restarts a running command, the idle code stops it
        apb(1'b1, `NFCCI_IDX_REQ, 8'h7F);
        apb(1'b1, `NFCCI_IDX_CMD, 8'h03);
        apb(1'b1, `NFCCI_IDX_CMD, 8'h0C);
        #1;
        chk("restart_start", 32'h1, {31'h0, cmd_start_o});
        chk("restart_code", 32'hC, {28'h0, cmd_code_o});
        apb(1'b1, `NFCCI_IDX_CMD, 8'h00);
        #1;
        chk("stop_start", 32'h0, {31'h0, cmd_start_o});
        chk("stop_code", 32'h0, {28'h0, cmd_code_o});
        apb(1'b0, `NFCCI_IDX_REQ, 8'h00);
        chk("stop_idle_flag", 32'h10, rd);
        // enables, polarity and drive type against events
        for (int i = 0; i < 10; i++) begin
            en = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($random(seed));
            ev = (i < 2) ? 7'h7F : 7'($random(seed));
            pol = 1'($random(seed));
            drv = 1'($random(seed));
            apb(1'b1, `NFCCI_IDX_REQ, 8'h7F);
            apb(1'b1, `NFCCI_IDX_IEN2, {drv, 7'h00});
            apb(1'b1, `NFCCI_IDX_IEN1, {pol, en});
            apb(1'b0, `NFCCI_IDX_IEN1, 8'h00);
            chk("ien1_rd", {24'h0, pol, en}, rd);
            @(posedge pclk);
            req_event_i <= ev;
            @(posedge pclk);
            req_event_i <= 7'h00;
            repeat (2) @(posedge pclk);
            #1;
            st = |(ev & en);
            chk("irq_o", {31'h0, st}, {31'h0, irq_o});
            chk_pin(st, pol, drv);
            apb(1'b0, `NFCCI_IDX_REQ, 8'h00);
            chk("req_flags", {25'h0, ev}, rd);
            apb(1'b0, `NFCCI_IDX_STAT1, 8'h00);
            chk("status", {31'h0, st}, {31'h0, rd[0]});
            // write one clears the flags, so the pin returns to inactive
            apb(1'b1, `NFCCI_IDX_REQ, {1'b0, ev});
            repeat (2) @(posedge pclk);
            #1;
            chk("irq_clr", 32'h0, {31'h0, irq_o});
            chk_pin(1'b0, pol, drv);
        end
        finish_test();
    end
endmodule
`default_nettype wire
